// *** rtl/uwc_ctrl.sv ***
// Keep-alive wake filter and crystal-less clock recovery control with register port
//
// Functional notes
// - Wake endpoint field, read-only, resets zero.
// - Wake token select field RW, resets 0001.
// - Select 0001 wakes on OUT or SETUP.
// - Select 1101 wakes on SETUP only.
// - Recovery keeps trimming oscillator to bus clock.
// - Control bit 7 enables recovery, reset off.
// - Rough phase, larger steps, then tracking.
// - Bit 6 set: reset/resume returns to rough.
// - Fine trim starts at factory value, updates.
// - Bit 5 set: reload factory trim on events.
// - Keep-alive: wake on selected tokens, NAK others.
// - Wake flag set after token processed, core idle.
`timescale 1ns/100ps
module uwc_ctrl import uwc_pkg::*; #(
  parameter int unsigned             TW          = uwc_pkg::TRIM_W,
  parameter logic [uwc_pkg::TRIM_W-1:0] FACTORY_TRIM = 8'h80
) (
  input  wire logic                        core_clk_i,     // 200 MHz clock
  input  wire logic                        arst_n_i,       // Async reset, active low
  input  wire logic                        clk_en_i,       // Clock enable, freezes state
  input  wire logic [uwc_pkg::ADDR_W-1:0]  reg_addr_i,     // Register byte address
  input  wire logic [uwc_pkg::DATA_W-1:0]  reg_wdata_i,    // Write data
  input  wire logic                        reg_wr_i,       // Write strobe
  input  wire logic                        reg_rd_i,       // Read strobe
  output logic      [uwc_pkg::DATA_W-1:0]  reg_rdata_o,    // Read data, cycle after strobe
  input  wire logic                        keepalive_en_i, // Keep-alive mode active
  input  wire logic                        tok_valid_i,    // Token received, one cycle
  input  wire logic [3:0]                  tok_pid_i,      // Token PID
  input  wire logic [3:0]                  tok_ep_i,       // Token endpoint
  input  wire logic                        core_idle_i,    // Core state is idle
  output logic                             nak_force_o,    // Force NAK for current token
  output logic                             wake_core_o,    // Wake request to core
  input  wire logic [1:0]                  link_state_i,   // Bus state
  input  wire logic                        meas_valid_i,   // New frame measurement
  input  wire logic                        meas_fast_i,    // Oscillator runs fast
  input  wire logic                        meas_slow_i,    // Oscillator runs slow
  input  wire logic [uwc_pkg::ERR_W-1:0]   meas_err_i,     // Error magnitude
  output logic      [uwc_pkg::TRIM_W-1:0]  trim_fine_o,    // Fine trim to oscillator
  output logic                             rough_phase_o,  // Rough phase active
  output logic                             irq_o           // Level interrupt
);
  import uwc_pkg::*;

  // Refused at elaboration: trim word is read back through the byte-wide register port
  if (TW != TRIM_W) begin
    $error("uwc_ctrl: TW must equal TRIM_W");
  end

  // Register state
  logic [3:0]         wake_sel_q;
  logic [3:0]         wake_ep_q;
  logic               cr_en_q;
  logic               cr_rough_q;
  logic               cr_reload_q;
  logic [4:0]         cr_rsvd_q;
  logic [IRQ_W-1:0]   irq_sts_q;
  logic [IRQ_W-1:0]   irq_en_q;
  logic [DATA_W-1:0]  rdata_q;

  // Wake path state
  logic               wake_pend_q;
  logic [3:0]         pend_ep_q;
  logic               nak_q;
  logic               wake_q;

  // Recovery state
  uwc_cr_state_t      cr_state_q;
  uwc_cr_state_t      cr_state_d;
  logic               locked_once_q;
  logic [TW-1:0]      trim_q;
  logic [1:0]         link_q;
  logic               cr_en_prev_q;
  logic               irq_q;
  logic               rough_q;

  // Decode
  wire sel_wake   = reg_addr_i == ADDR_WAKE_CTRL;
  wire sel_clkrec = reg_addr_i == ADDR_CLKREC_CTRL;
  wire sel_ists   = reg_addr_i == ADDR_IRQ_STATUS;
  wire sel_ien    = reg_addr_i == ADDR_IRQ_ENABLE;
  wire sel_iclr   = reg_addr_i == ADDR_IRQ_CLEAR;
  wire sel_trim   = reg_addr_i == ADDR_TRIM_STAT;
  wire wr_wake    = reg_wr_i & sel_wake;
  wire wr_clkrec  = reg_wr_i & sel_clkrec;
  wire wr_ien     = reg_wr_i & sel_ien;
  wire wr_iclr    = reg_wr_i & sel_iclr;

  // Unmapped and write-only addresses read as zero
  wire [DATA_W-1:0] rd_mux =
    sel_wake   ? {wake_ep_q, wake_sel_q} :
    sel_clkrec ? {cr_en_q, cr_rough_q, cr_reload_q, cr_rsvd_q} :
    sel_ists   ? {{(DATA_W-IRQ_W){1'b0}}, irq_sts_q} :
    sel_ien    ? {{(DATA_W-IRQ_W){1'b0}}, irq_en_q} :
    sel_trim   ? trim_q : {DATA_W{1'b0}};

  // Token filter
  wire is_setup   = tok_pid_i == PID_SETUP;
  wire is_out     = tok_pid_i == PID_OUT;
  wire sel_os     = wake_sel_q == WAKE_SEL_OUT_SETUP;
  // Reserved select codes fall back to SETUP only, so setup always wakes
  wire tok_wakes  = is_setup | (sel_os & is_out);
  wire tok_hit    = keepalive_en_i & tok_valid_i & tok_wakes;
  wire tok_nak    = keepalive_en_i & tok_valid_i & ~tok_wakes;
  // Flag waits until the token is done and the core is back to idle
  wire wake_fire  = wake_pend_q & core_idle_i & ~tok_hit;

  // Bus events, one cycle each on entry to the state
  wire ev_reset   = (link_state_i == LINK_RESET) & (link_q != LINK_RESET);
  wire ev_resume  = (link_state_i == LINK_RESUME) & (link_q != LINK_RESUME);
  wire bus_ev     = ev_reset | ev_resume;
  wire en_fall    = cr_en_prev_q & ~cr_en_q;
  wire reload     = cr_reload_q & (bus_ev | en_fall);
  wire rough_exit = meas_valid_i & (meas_err_i <= ROUGH_LOCK_ERR);

  // Phase machine
  always_comb begin
    cr_state_d = cr_state_q;
    case (cr_state_q)
      UWC_CR_OFF: begin
        if (cr_en_q) begin
          cr_state_d = locked_once_q & ~cr_rough_q ? UWC_CR_TRACK : UWC_CR_ROUGH;
        end
      end
      UWC_CR_ROUGH: begin
        if (!cr_en_q) begin
          cr_state_d = UWC_CR_OFF;
        end else if (rough_exit) begin
          cr_state_d = UWC_CR_TRACK;
        end
      end
      UWC_CR_TRACK: begin
        if (!cr_en_q) begin
          cr_state_d = UWC_CR_OFF;
        end else if (cr_rough_q && bus_ev) begin
          cr_state_d = UWC_CR_ROUGH;
        end
      end
      default: cr_state_d = UWC_CR_OFF;
    endcase
  end

  wire           in_rough = cr_state_q == UWC_CR_ROUGH;
  wire           adjust   = cr_en_q & meas_valid_i & (cr_state_q != UWC_CR_OFF);
  wire [TW-1:0]  step     = in_rough ? STEP_ROUGH : STEP_TRACK;
  wire [TW-1:0]  trim_nx;

  uwc_trim_step #(
    .W (TW)
  ) u_step (
    .trim_i   (trim_q),
    .step_i   (step),
    .faster_i (meas_slow_i),
    .slower_i (meas_fast_i),
    .trim_o   (trim_nx)
  );

  wire rough_done = in_rough & (cr_state_d == UWC_CR_TRACK);
  wire [IRQ_W-1:0] irq_set = {rough_done, wake_fire};
  // Set wins over a clear in the same cycle
  wire [IRQ_W-1:0] irq_sts_d =
    irq_set | (irq_sts_q & ~(wr_iclr ? reg_wdata_i[IRQ_W-1:0] : {IRQ_W{1'b0}}));
  // Next enable, so the line follows an enable write in the same cycle as a status change
  wire [IRQ_W-1:0] irq_en_d = wr_ien ? reg_wdata_i[IRQ_W-1:0] : irq_en_q;

  // Software registers
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wake_sel_q  <= WAKE_SEL_RST;
      cr_en_q     <= 1'b0;
      cr_rough_q  <= 1'b0;
      cr_reload_q <= 1'b0;
      cr_rsvd_q   <= CR_RSVD_RST;
      irq_en_q    <= '0;
      rdata_q     <= '0;
    end else if (clk_en_i) begin
      if (wr_wake) begin
        wake_sel_q <= reg_wdata_i[WAKE_SEL_LSB +: 4];
      end
      if (wr_clkrec) begin
        cr_en_q     <= reg_wdata_i[CR_EN_BIT];
        cr_rough_q  <= reg_wdata_i[CR_ROUGH_BIT];
        cr_reload_q <= reg_wdata_i[CR_RELOAD_BIT];
        // Low bits are stored as written; software is expected to keep them
        cr_rsvd_q   <= reg_wdata_i[4:0];
      end
      if (wr_ien) begin
        irq_en_q <= reg_wdata_i[IRQ_W-1:0];
      end
      rdata_q <= reg_rd_i ? rd_mux : '0;
    end
  end

  // Wake capture
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wake_ep_q   <= '0;
      wake_pend_q <= 1'b0;
      pend_ep_q   <= '0;
      nak_q       <= 1'b0;
      wake_q      <= 1'b0;
    end else if (clk_en_i) begin
      if (tok_hit) begin
        wake_pend_q <= 1'b1;
        pend_ep_q   <= tok_ep_i;
      end else if (wake_fire) begin
        wake_pend_q <= 1'b0;
      end
      if (wake_fire) begin
        wake_ep_q <= pend_ep_q;
      end
      nak_q  <= tok_nak;
      wake_q <= tok_hit;
    end
  end

  // Recovery phase and trim
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cr_state_q    <= UWC_CR_OFF;
      locked_once_q <= 1'b0;
      trim_q        <= FACTORY_TRIM;
      link_q        <= LINK_IDLE;
      cr_en_prev_q  <= 1'b0;
      irq_sts_q     <= '0;
      irq_q         <= 1'b0;
      rough_q       <= 1'b0;
    end else if (clk_en_i) begin
      cr_state_q   <= cr_state_d;
      link_q       <= link_state_i;
      cr_en_prev_q <= cr_en_q;
      if (rough_done) begin
        locked_once_q <= 1'b1;
      end
      if (reload) begin
        trim_q <= FACTORY_TRIM;
      end else if (adjust) begin
        trim_q <= trim_nx;
      end
      irq_sts_q <= irq_sts_d;
      irq_q     <= |(irq_sts_d & irq_en_d);
      rough_q   <= (cr_state_d == UWC_CR_ROUGH);
    end
  end

  assign reg_rdata_o   = rdata_q;
  assign nak_force_o   = nak_q;
  assign wake_core_o   = wake_q;
  assign trim_fine_o   = trim_q;
  assign rough_phase_o = rough_q;
  assign irq_o         = irq_q;
endmodule

// *** rtl/uwc_pkg.sv ***
// Package: register map, field positions, resets and trim steps for the USB wake and recovery block
package uwc_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_WAKE_CTRL = 12'h128;
  localparam logic [ADDR_W-1:0] ADDR_CLKREC_CTRL = 12'h140;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 12'h180;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE = 12'h184;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_CLEAR = 12'h188;
  localparam logic [ADDR_W-1:0] ADDR_TRIM_STAT = 12'h18c;
  // Wake control fields
  localparam int unsigned WAKE_EP_LSB = 4;
  localparam int unsigned WAKE_SEL_LSB = 0;
  localparam logic [3:0] WAKE_SEL_RST = 4'h1;
  localparam logic [3:0] WAKE_SEL_OUT_SETUP = 4'h1;
  localparam logic [3:0] WAKE_SEL_SETUP = 4'hd;
  // Clock recovery control fields
  localparam int unsigned CR_EN_BIT = 7;
  localparam int unsigned CR_ROUGH_BIT = 6;
  localparam int unsigned CR_RELOAD_BIT = 5;
  localparam logic [4:0] CR_RSVD_RST = 5'h00;
  // Interrupt status bits
  localparam int unsigned IRQ_W = 2;
  localparam int unsigned IRQ_WAKE = 0;
  localparam int unsigned IRQ_ROUGH_DONE = 1;
  // PID codes of tokens
  localparam logic [3:0] PID_OUT = 4'h1;
  localparam logic [3:0] PID_SETUP = 4'hd;
  // Link states
  localparam logic [1:0] LINK_IDLE = 2'h0;
  localparam logic [1:0] LINK_RESET = 2'h1;
  localparam logic [1:0] LINK_RESUME = 2'h2;
  localparam logic [1:0] LINK_ACTIVE = 2'h3;
  // Trim steps and rough phase exit threshold
  localparam int unsigned TRIM_W = 8;
  localparam logic [TRIM_W-1:0] STEP_ROUGH = 8'h04;
  localparam logic [TRIM_W-1:0] STEP_TRACK = 8'h01;
  localparam int unsigned ERR_W = 8;
  localparam logic [ERR_W-1:0] ROUGH_LOCK_ERR = 8'h04;
  typedef enum logic [1:0] {UWC_CR_OFF, UWC_CR_ROUGH, UWC_CR_TRACK} uwc_cr_state_t;
endpackage

// *** rtl/uwc_trim_step.sv ***
// Trim step unit: moves the fine trim word one step in the measured direction with saturation
`timescale 1ns/100ps
module uwc_trim_step import uwc_pkg::*; #(
  parameter int unsigned W = uwc_pkg::TRIM_W
) (
  input  wire logic [W-1:0]    trim_i,     // Present trim value
  input  wire logic [W-1:0]    step_i,     // Step size
  input  wire logic            faster_i,   // Oscillator slow: raise trim
  input  wire logic            slower_i,   // Oscillator fast: lower trim
  output logic      [W-1:0]    trim_o      // Next trim value
);
  // Refused at elaboration: the saturation logic needs at least two bits
  if (W < 2) begin
    $error("uwc_trim_step: W too small");
  end
  wire [W:0] up_sum = {1'b0, trim_i} + {1'b0, step_i};
  wire       dn_neg = step_i > trim_i;
  wire [W-1:0] dn_val = trim_i - step_i;
  // Saturate rather than wrap: a wrapped trim swings the oscillator end to end
  assign trim_o = faster_i ? (up_sum[W] ? {W{1'b1}} : up_sum[W-1:0]) :
                  slower_i ? (dn_neg ? {W{1'b0}} : dn_val) : trim_i;
endmodule

// *** bench/uwc_ctrl_sva.sv ***
// Checker of the wake filter and clock recovery behaviour at the block ports
`timescale 1ns/100ps
module uwc_ctrl_sva (
  input wire logic                        core_clk_i,     // Clock
  input wire logic                        arst_n_i,       // Reset, active low
  input wire logic                        reg_wr_i,       // Write strobe
  input wire logic                        reg_rd_i,       // Read strobe
  input wire logic [uwc_pkg::DATA_W-1:0]  reg_rdata_o,    // Read data
  input wire logic                        keepalive_en_i, // Keep-alive mode
  input wire logic                        tok_valid_i,    // Token strobe
  input wire logic [3:0]                  tok_pid_i,      // Token PID
  input wire logic                        nak_force_o,    // NAK pulse
  input wire logic                        wake_core_o,    // Wake pulse
  input wire logic [1:0]                  link_state_i,   // Bus state
  input wire logic                        meas_valid_i,   // Measurement strobe
  input wire logic                        meas_fast_i,    // Oscillator fast
  input wire logic                        meas_slow_i,    // Oscillator slow
  input wire logic [uwc_pkg::ERR_W-1:0]   meas_err_i,     // Error magnitude
  input wire logic [uwc_pkg::TRIM_W-1:0]  trim_fine_o,    // Fine trim
  input wire logic                        rough_phase_o   // Rough phase
);
  import uwc_pkg::*;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  a_setup_wakes: assert property (tok_valid_i && keepalive_en_i && tok_pid_i == PID_SETUP
    |=> wake_core_o && !nak_force_o) else $error("setup token did not wake");
  a_other_naks: assert property (tok_valid_i && keepalive_en_i && tok_pid_i != PID_SETUP
    && tok_pid_i != PID_OUT |=> nak_force_o && !wake_core_o) else $error("token not refused");
  a_idle_quiet: assert property (!(tok_valid_i && keepalive_en_i)
    |=> !wake_core_o && !nak_force_o) else $error("pulse without token");
  a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data without strobe");
  a_rough_step: assert property (rough_phase_o && meas_valid_i && meas_slow_i && !meas_fast_i
    && meas_err_i > ROUGH_LOCK_ERR && trim_fine_o <= 8'hfb && !reg_wr_i
    && $stable(link_state_i) && link_state_i == LINK_ACTIVE
    |=> trim_fine_o == $past(trim_fine_o) + STEP_ROUGH) else $error("rough step wrong");
  a_track_step: assert property (($fell(rough_phase_o) && !$past(reg_wr_i)) ##1
    (meas_valid_i && meas_slow_i && !meas_fast_i && trim_fine_o != 8'hff && !reg_wr_i
    && $stable(link_state_i) && link_state_i == LINK_ACTIVE)
    |=> trim_fine_o == $past(trim_fine_o) + STEP_TRACK) else $error("tracking step wrong");
  a_rough_exit: assert property (rough_phase_o && meas_valid_i && meas_err_i <= ROUGH_LOCK_ERR
    && !reg_wr_i && $stable(link_state_i) && link_state_i == LINK_ACTIVE
    |=> !rough_phase_o) else $error("rough phase not left");
  a_trim_hold: assert property (!meas_valid_i && !reg_wr_i && !$past(reg_wr_i)
    && $stable(link_state_i) && link_state_i == $past(link_state_i, 2)
    |=> $stable(trim_fine_o)) else $error("trim moved without cause");
endmodule
bind uwc_ctrl uwc_ctrl_sva i_uwc_ctrl_sva (.core_clk_i, .arst_n_i, .reg_wr_i, .reg_rd_i,
  .reg_rdata_o, .keepalive_en_i, .tok_valid_i, .tok_pid_i, .nak_force_o, .wake_core_o,
  .link_state_i, .meas_valid_i, .meas_fast_i, .meas_slow_i, .meas_err_i, .trim_fine_o,
  .rough_phase_o);

// *** bench/uwc_host_model.sv ***
// Host side model: tokens, bus state and frame measurements
`timescale 1ns/100ps
module uwc_host_model (
  input  wire logic                       clk_i,        // Bench clock
  output logic                            tok_valid_o,  // Token strobe
  output logic [3:0]                      tok_pid_o,    // Token PID
  output logic [3:0]                      tok_ep_o,     // Token endpoint
  output logic [1:0]                      link_state_o, // Bus state
  output logic                            meas_valid_o, // Measurement strobe
  output logic                            meas_fast_o,  // Oscillator fast
  output logic                            meas_slow_o,  // Oscillator slow
  output logic [uwc_pkg::ERR_W-1:0]       meas_err_o    // Error magnitude
);
  import uwc_pkg::*;
  initial begin
    {tok_valid_o, tok_pid_o, tok_ep_o, meas_valid_o, meas_fast_o, meas_slow_o} = '0;
    meas_err_o = 8'h00;
    link_state_o = LINK_ACTIVE;
  end
  // Released qualifiers show inverted values so stale data never looks valid
  task automatic token(input logic [3:0] pid, input logic [3:0] ep);
    @(posedge clk_i);
    {tok_valid_o, tok_pid_o, tok_ep_o} <= {1'b1, pid, ep};
    @(posedge clk_i);
    {tok_valid_o, tok_pid_o, tok_ep_o} <= {1'b0, ~pid, ~ep};
  endtask
  task automatic meas(input logic fast, input logic slow, input logic [7:0] err);
    @(posedge clk_i);
    {meas_valid_o, meas_fast_o, meas_slow_o, meas_err_o} <= {1'b1, fast, slow, err};
    @(posedge clk_i);
    {meas_valid_o, meas_fast_o, meas_slow_o, meas_err_o} <= {1'b0, ~fast, ~slow, ~err};
  endtask
  task automatic link(input logic [1:0] s);
    @(posedge clk_i);
    link_state_o <= s;
    repeat (2) @(posedge clk_i);
    link_state_o <= LINK_ACTIVE;
  endtask
endmodule

// *** bench/usb_wake_and_clock_recovery_ctrl_test.sv ***
// Testbench of the USB wake filter and clock recovery control block
`timescale 1ns/100ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin miscompares++; \
  $display("unexpected at %0t: got %h exp %h", $time, (a), (e)); end end
module usb_wake_and_clock_recovery_ctrl_test;
  import uwc_pkg::*;
  logic              core_clk_i = 1'b0;
  logic              arst_n_i = 1'b0;
  logic [ADDR_W-1:0] reg_addr_i = '0;
  logic [7:0]        reg_wdata_i = '0;
  logic              reg_wr_i = 1'b0;
  logic              reg_rd_i = 1'b0;
  logic              keepalive_en_i = 1'b1;
  logic              core_idle_i = 1'b1;
  wire logic [7:0]   reg_rdata_o, trim_fine_o, meas_err_i;
  wire logic [3:0]   tok_pid_i, tok_ep_i;
  wire logic [1:0]   link_state_i;
  wire logic         tok_valid_i, nak_force_o, wake_core_o, meas_valid_i, meas_fast_i;
  wire logic         meas_slow_i, rough_phase_o, irq_o;
  int                miscompares = 0;
  int                n_compared = 0;
  int                seed = 39497;
  int                i;
  logic [7:0]        d, t;
  logic [3:0]        sel, pid, ep, last_ep;
  logic              exp, up;
  always #2.5 core_clk_i = ~core_clk_i;
  uwc_ctrl #(.FACTORY_TRIM(8'h5a)) i_uwc_ctrl (.core_clk_i, .arst_n_i, .clk_en_i(1'b1),
    .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .keepalive_en_i,
    .tok_valid_i, .tok_pid_i, .tok_ep_i, .core_idle_i, .nak_force_o, .wake_core_o,
    .link_state_i, .meas_valid_i, .meas_fast_i, .meas_slow_i, .meas_err_i, .trim_fine_o,
    .rough_phase_o, .irq_o);
  uwc_host_model i_uwc_host_model (.clk_i(core_clk_i), .tok_valid_o(tok_valid_i),
    .tok_pid_o(tok_pid_i), .tok_ep_o(tok_ep_i), .link_state_o(link_state_i),
    .meas_valid_o(meas_valid_i), .meas_fast_o(meas_fast_i), .meas_slow_o(meas_slow_i),
    .meas_err_o(meas_err_i));
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] v);
    @(posedge core_clk_i);
    {reg_addr_i, reg_wdata_i, reg_wr_i} <= {a, v, 1'b1};
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] v);
    @(posedge core_clk_i);
    {reg_addr_i, reg_rd_i} <= {a, 1'b1};
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 v = reg_rdata_o;
  endtask
  function automatic logic [7:0] nxt(input logic [7:0] v, input logic [7:0] s, input logic u);
    if (u) begin
      return (v > 8'hff - s) ? 8'hff : v + s;
    end
    return (v < s) ? 8'h00 : v - s;
  endfunction
  // One step of recovery with a random direction; large error keeps the phase
  task automatic step(input logic [7:0] s);
    up = $random(seed);
    i_uwc_host_model.meas(!up, up, 8'h20);
    #1 t = nxt(t, s, up);
    `CHK(trim_fine_o, t)
  endtask
  task automatic end_of_test;
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge core_clk_i);
    miscompares++;
    end_of_test();
  end
  initial begin
    repeat (12) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    rd(ADDR_WAKE_CTRL, d);
    `CHK(d, 8'h01)
    rd(ADDR_CLKREC_CTRL, d);
    `CHK(d, 8'h00)
    rd(12'h1f0, d);
    `CHK(d, 8'h00)
    wr(ADDR_IRQ_ENABLE, 8'h01);
    last_ep = 4'h0;
    for (i = 0; i < 6; i++) begin
      sel = (i < 3) ? WAKE_SEL_OUT_SETUP : WAKE_SEL_SETUP;
      pid = (i % 3 == 0) ? PID_OUT : (i % 3 == 1) ? PID_SETUP : 4'h9;
      ep = $random(seed);
      exp = (pid == PID_SETUP) || (pid == PID_OUT && sel == WAKE_SEL_OUT_SETUP);
      wr(ADDR_WAKE_CTRL, {~last_ep, sel});
      i_uwc_host_model.token(pid, ep);
      #1 `CHK({wake_core_o, nak_force_o}, {exp, !exp})
      if (exp) last_ep = ep;
      rd(ADDR_WAKE_CTRL, d);
      `CHK(d, {last_ep, sel})
      `CHK(irq_o, exp)
      wr(ADDR_IRQ_CLEAR, 8'h01);
      `CHK(irq_o, 1'b0)
      $display("wake case %0d done", i);
    end
    keepalive_en_i <= 1'b0;
    i_uwc_host_model.token(PID_SETUP, 4'h2);
    #1 `CHK(wake_core_o, 1'b0)
    keepalive_en_i <= 1'b1;
    core_idle_i <= 1'b0;
    wr(ADDR_IRQ_ENABLE, 8'h00);
    i_uwc_host_model.token(PID_SETUP, 4'h6);
    repeat (4) @(posedge core_clk_i);
    rd(ADDR_IRQ_STATUS, d);
    `CHK(d[IRQ_WAKE], 1'b0)
    core_idle_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    `CHK(irq_o, 1'b0)
    wr(ADDR_IRQ_ENABLE, 8'h01);
    `CHK(irq_o, 1'b1)
    rd(ADDR_WAKE_CTRL, d);
    `CHK(d[7:4], 4'h6)
    wr(ADDR_IRQ_CLEAR, 8'h01);
    $display("keep-alive tests done");
    t = 8'h5a;
    `CHK(trim_fine_o, t)
    wr(ADDR_CLKREC_CTRL, 8'h80);
    #5 `CHK(rough_phase_o, 1'b1)
    repeat (4) step(STEP_ROUGH);
    i_uwc_host_model.meas(1'b0, 1'b0, ROUGH_LOCK_ERR);
    #1 `CHK({rough_phase_o, trim_fine_o}, {1'b0, t})
    rd(ADDR_IRQ_STATUS, d);
    `CHK(d[IRQ_ROUGH_DONE], 1'b1)
    rd(ADDR_TRIM_STAT, d);
    `CHK(d, t)
    repeat (4) step(STEP_TRACK);
    i_uwc_host_model.link(LINK_RESET);
    repeat (3) @(posedge core_clk_i);
    `CHK(rough_phase_o, 1'b0)
    wr(ADDR_CLKREC_CTRL, 8'hc0);
    i_uwc_host_model.link(LINK_RESUME);
    repeat (3) @(posedge core_clk_i);
    `CHK({rough_phase_o, trim_fine_o}, {1'b1, t})
    wr(ADDR_CLKREC_CTRL, 8'he0);
    i_uwc_host_model.link(LINK_RESET);
    repeat (3) @(posedge core_clk_i);
    t = 8'h5a;
    `CHK(trim_fine_o, t)
    step(STEP_ROUGH);
    wr(ADDR_CLKREC_CTRL, 8'h20);
    repeat (2) @(posedge core_clk_i);
    `CHK({rough_phase_o, trim_fine_o}, {1'b0, 8'h5a})
    $display("recovery tests done");
    end_of_test();
  end
endmodule
